// ### hw/pihi_defs.svh
// timing, decode and reset constants of the disk host interface
// assumes a 200 MHz bus clock and a synchronous reset
`ifndef PIHI_DEFS_SVH
`define PIHI_DEFS_SVH

// bus clock period in ns
`define PIHI_CLK_PERIOD_NS 5
// least width of a drive read or write strobe, in ns
`define PIHI_STROBE_NS 120
// strobe width in clock cycles, rounded up
`define PIHI_STROBE_CYC \
  ((`PIHI_STROBE_NS + `PIHI_CLK_PERIOD_NS - 1) / `PIHI_CLK_PERIOD_NS)

// bus commands of the address phase
`define PIHI_CMD_IO_RD  4'h2
`define PIHI_CMD_IO_WR  4'h3
`define PIHI_CMD_CFG_RD 4'hA
`define PIHI_CMD_CFG_WR 4'hB

// default legacy port windows, command block and control port
`define PIHI_PRI_CMD_BASE 32'h000001F0
`define PIHI_PRI_CTL_PORT 32'h000003F6
`define PIHI_SEC_CMD_BASE 32'h00000170
`define PIHI_SEC_CTL_PORT 32'h00000376
// register index of the control port inside the drive
`define PIHI_CTL_REG_IDX  3'h6

// reset value of the captured strap: high means no serial load
`define PIHI_STRAP_RST 1'b1

`endif

// ### hw/pihi_irq.sv
// legacy interrupt route of one drive channel
// assumes intrq_i is an asynchronous drive pin, native_i is on core_clk_i
module pihi_irq
  import pihi_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic intrq_i,
  input  wire logic native_i,
  output wire logic irq_o,
  output wire logic irq_oe_o
);

  pihi_irq_t r;       // registered state
  pihi_irq_t next_r;  // next state

  // sync the drive request; release the line in native mode
  always_comb begin
    next_r    = r;
    next_r.q1 = intrq_i;
    next_r.q2 = r.q1;
    next_r.oe = ~native_i;
    if (rst_i) begin
      next_r.oe = 1'b0;
    end
  end

  // one register for the whole state
  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  assign irq_o    = r.q2;
  assign irq_oe_o = r.oe;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  native_float_a: assert property (
    native_i |=> !irq_oe_o)
    else $error("legacy interrupt driven in native mode");

  legacy_follow_a: assert property (
    !native_i ##1 !$past(rst_i, 2) |-> irq_oe_o &&
      irq_o == $past(intrq_i, 2))
    else $error("legacy interrupt does not follow the drive");

endmodule // pihi_irq

// ### hw/pihi_pkg.sv
// types shared by the disk host interface modules
// assumes pihi_defs.svh for the numeric constants
package pihi_pkg;

  // target sequencer states, one-hot
  typedef enum logic [8:0] {
    PIHI_IDLE   = 9'h001,  // bus idle, watching for an address phase
    PIHI_BUSY   = 9'h002,  // foreign transaction in progress
    PIHI_WDATA  = 9'h004,  // claimed write, waiting for master data
    PIHI_SETUP  = 9'h008,  // drive address and select settling
    PIHI_STROBE = 9'h010,  // drive read or write strobe active
    PIHI_READY  = 9'h020,  // target ready, waiting for initiator
    PIHI_RETRY  = 9'h040,  // stop without data
    PIHI_STOPW  = 9'h080,  // stop held after disconnect with data
    PIHI_TURN   = 9'h100   // control lines driven high, then released
  } pihi_state_t;

  // width of the strobe counter
  localparam int PIHI_CNT_W = 8;

  // whole state of the target sequencer
  typedef struct packed {
    pihi_state_t           state;
    logic                  is_read;
    logic                  is_cfg;
    logic                  chan;
    logic                  cs1;
    logic [2:0]            reg_addr;
    logic [1:0]            lane;
    logic [PIHI_CNT_W-1:0] cnt;
    logic [15:0]           wdata;
    logic [31:0]           ad_out;
    logic [31:0]           dq1;
    logic [31:0]           dq2;
  } pihi_tgt_t;

  // state of the strap catcher
  typedef struct packed {
    logic s1;
    logic s2;
    logic in_rst;
    logic latched;
    logic loading;
  } pihi_strap_t;

  // state of one legacy interrupt route
  typedef struct packed {
    logic q1;
    logic q2;
    logic oe;
  } pihi_irq_t;

endpackage : pihi_pkg

// ### hw/pihi_strap.sv
// strap catcher: latches the float/config strap at reset release
// assumes strap_i is an asynchronous pin, load_done_i is on core_clk_i
`include "pihi_defs.svh"
module pihi_strap
  import pihi_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic strap_i,
  input  wire logic load_done_i,
  output wire logic strap_latched_o,
  output wire logic load_req_o,
  output wire logic float_o
);

  pihi_strap_t r;       // registered state
  pihi_strap_t next_r;  // next state

  // next state; the synchroniser keeps running through reset so that
  // the value seen at release is already settled
  always_comb begin
    next_r    = r;
    next_r.s1 = strap_i;
    next_r.s2 = r.s1;
    if (r.in_rst) begin
      // first cycle after release: take the pin level
      next_r.in_rst  = 1'b0;
      next_r.latched = r.s2;
      next_r.loading = ~r.s2;
    end else if (r.loading && load_done_i) begin
      next_r.loading = 1'b0;
    end
    if (rst_i) begin
      next_r.in_rst  = 1'b1;
      next_r.latched = `PIHI_STRAP_RST;
      next_r.loading = 1'b0;
    end
  end

  // one register for the whole state, bus clock edge
  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  assign strap_latched_o = r.latched;
  assign load_req_o      = r.loading;
  // live strap low in normal operation floats the drive side
  assign float_o         = ~r.in_rst & ~r.s2;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  strap_capture_a: assert property (
    r.in_rst |=> strap_latched_o == $past(r.s2))
    else $error("strap not captured at reset release");

  strap_hold_a: assert property (
    !r.in_rst |=> $stable(strap_latched_o))
    else $error("captured strap changed outside reset");

  serial_load_a: assert property (
    r.in_rst && !r.s2 |=> load_req_o until_with load_done_i)
    else $error("serial load not requested for low strap");

endmodule // pihi_strap

// ### hw/pihi_top.sv
// disk host interface: bus target, drive strobes, strap and interrupts
// assumes the bus pins are on core_clk_i; drive pins are asynchronous
`include "pihi_defs.svh"
module pihi_top
  import pihi_pkg::*;
#(
  parameter logic [31:0] PRI_CMD_BASE = `PIHI_PRI_CMD_BASE,
  parameter logic [31:0] PRI_CTL_PORT = `PIHI_PRI_CTL_PORT,
  parameter logic [31:0] SEC_CMD_BASE = `PIHI_SEC_CMD_BASE,
  parameter logic [31:0] SEC_CTL_PORT = `PIHI_SEC_CTL_PORT,
  parameter int          STROBE_CYC   = `PIHI_STROBE_CYC
)(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // bus side
  input  wire logic        idsel_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic [3:0]  cbe_n_i,
  input  wire logic [31:0] ad_i,
  output wire logic [31:0] ad_o,
  output wire logic        ad_oe_o,
  output wire logic        trdy_n_o,
  output wire logic        trdy_n_oe_o,
  output wire logic        devsel_n_o,
  output wire logic        devsel_n_oe_o,
  output wire logic        stop_n_o,
  output wire logic        stop_n_oe_o,
  // strap and serial configuration load
  input  wire logic        strap_i,
  input  wire logic        serial_load_done_i,
  output wire logic        serial_load_req_o,
  output wire logic        strap_latched_o,
  // channel modes and drive interrupts
  input  wire logic        pri_native_i,
  input  wire logic        sec_native_i,
  input  wire logic        pri_intrq_i,
  input  wire logic        sec_intrq_i,
  output wire logic        primary_legacy_irq_o,
  output wire logic        primary_legacy_irq_oe_o,
  output wire logic        secondary_legacy_irq_o,
  output wire logic        secondary_legacy_irq_oe_o,
  // primary drive channel
  output wire logic        pri_chip_select_0_n_o,
  output wire logic        pri_chip_select_1_n_o,
  output wire logic        pri_io_read_n_o,
  output wire logic        pri_io_write_n_o,
  output wire logic [2:0]  pri_addr_o,
  output wire logic        pri_ctl_oe_o,
  input  wire logic [15:0] pri_data_i,
  output wire logic [15:0] pri_data_o,
  output wire logic        pri_data_oe_o,
  // secondary drive channel
  output wire logic        sec_chip_select_0_n_o,
  output wire logic        sec_chip_select_1_n_o,
  output wire logic        sec_io_read_n_o,
  output wire logic        sec_io_write_n_o,
  output wire logic [2:0]  sec_addr_o,
  output wire logic        sec_ctl_oe_o,
  input  wire logic [15:0] sec_data_i,
  output wire logic [15:0] sec_data_o,
  output wire logic        sec_data_oe_o
);

  // refuse strobe widths the counter cannot hold
  if (STROBE_CYC < 1 || STROBE_CYC > (1 << PIHI_CNT_W)) begin : g_chk
    $error("STROBE_CYC out of range for the strobe counter");
  end

  localparam logic [PIHI_CNT_W-1:0] STROBE_LAST =
    PIHI_CNT_W'(STROBE_CYC - 1);

  pihi_tgt_t r;        // registered state
  pihi_tgt_t next_r;   // next state
  logic      float_q;  // drive side floated by the live strap
  logic      loading;  // serial configuration load in progress
  logic      cfg_hit;  // address phase is a config cycle for us
  logic      io_hit;   // address phase falls in a port window
  logic      io_chan;  // window belongs to the secondary channel
  logic      io_cs1;   // window is the control port
  logic      addr_ph;  // this edge carries an address phase

  // byte of the addressed lane; lanes zero and two keep a full 16-bit word
  function automatic logic [15:0] lane_pick(logic [31:0] d,
                                            logic [1:0]  a);
    case (a)
      2'h1:    lane_pick = {8'h00, d[15:8]};
      2'h2:    lane_pick = d[31:16];
      2'h3:    lane_pick = {8'h00, d[31:24]};
      default: lane_pick = d[15:0];
    endcase
  endfunction

  // place drive data on the lane the master addressed
  function automatic logic [31:0] lane_place(logic [15:0] d,
                                             logic [1:0]  a);
    case (a)
      2'h1:    lane_place = {16'h0000, d[7:0], 8'h00};
      2'h2:    lane_place = {d, 16'h0000};
      2'h3:    lane_place = {d[7:0], 24'h000000};
      default: lane_place = {16'h0000, d};
    endcase
  endfunction

  // address decode of the address phase
  always_comb begin
    addr_ph = (r.state == PIHI_IDLE) && !frame_n_i;
    // the select input stands in for the upper address lines
    cfg_hit = idsel_i && (ad_i[1:0] == 2'h0) &&
              (cbe_n_i == `PIHI_CMD_CFG_RD ||
               cbe_n_i == `PIHI_CMD_CFG_WR);
    io_hit  = 1'b0;
    io_chan = 1'b0;
    io_cs1  = 1'b0;
    if (cbe_n_i == `PIHI_CMD_IO_RD || cbe_n_i == `PIHI_CMD_IO_WR) begin
      if (ad_i[31:3] == PRI_CMD_BASE[31:3]) begin
        io_hit = 1'b1;
      end else if (ad_i == PRI_CTL_PORT) begin
        io_hit = 1'b1;
        io_cs1 = 1'b1;
      end else if (ad_i[31:3] == SEC_CMD_BASE[31:3]) begin
        io_hit  = 1'b1;
        io_chan = 1'b1;
      end else if (ad_i == SEC_CTL_PORT) begin
        io_hit  = 1'b1;
        io_chan = 1'b1;
        io_cs1  = 1'b1;
      end
    end
  end

  // target sequencer next state
  always_comb begin
    next_r     = r;
    // drive data synchroniser, second stage read at strobe end only
    next_r.dq1 = {sec_data_i, pri_data_i};
    next_r.dq2 = r.dq1;
    case (r.state)
      PIHI_IDLE: begin
        if (addr_ph) begin
          next_r.is_read  = ~cbe_n_i[0];
          next_r.is_cfg   = cfg_hit;
          next_r.chan     = io_chan;
          next_r.cs1      = io_cs1;
          next_r.reg_addr = io_cs1 ? `PIHI_CTL_REG_IDX : ad_i[2:0];
          next_r.lane     = ad_i[1:0];
          next_r.ad_out   = 32'h00000000;
          if (cfg_hit && loading) begin
            next_r.state = PIHI_RETRY;
          end else if (cfg_hit) begin
            next_r.state = PIHI_READY;
          end else if (io_hit) begin
            next_r.state = cbe_n_i[0] ? PIHI_WDATA : PIHI_SETUP;
          end else begin
            next_r.state = PIHI_BUSY;
          end
        end
      end
      PIHI_BUSY: begin
        // bus idle again once both frame and initiator ready are off
        if (frame_n_i && irdy_n_i) begin
          next_r.state = PIHI_IDLE;
        end
      end
      PIHI_WDATA: begin
        // write data valid only with initiator ready
        if (!irdy_n_i) begin
          next_r.wdata = lane_pick(ad_i, r.lane);
          next_r.state = PIHI_SETUP;
        end
      end
      PIHI_SETUP: begin
        next_r.cnt   = STROBE_LAST;
        next_r.state = PIHI_STROBE;
      end
      PIHI_STROBE: begin
        if (r.cnt == '0) begin
          // read data is put on the bus at the same edge as target ready
          if (r.is_read) begin
            next_r.ad_out = lane_place(
              r.chan ? r.dq2[31:16] : r.dq2[15:0], r.lane);
          end
          next_r.state = PIHI_READY;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      PIHI_READY: begin
        // complete only on an edge with both readies sampled low
        if (!irdy_n_i) begin
          next_r.state = frame_n_i ? PIHI_TURN : PIHI_STOPW;
        end
      end
      PIHI_RETRY, PIHI_STOPW: begin
        // hold stop until the master ends its last phase
        if (frame_n_i && !irdy_n_i) begin
          next_r.state = PIHI_TURN;
        end
      end
      PIHI_TURN: begin
        // back-to-back cycles without an idle edge are not claimed
        next_r.state = PIHI_BUSY;
      end
      default: begin
        next_r.state = PIHI_IDLE;
      end
    endcase
    if (rst_i) begin
      next_r.state = PIHI_IDLE;
      next_r.cnt   = '0;
    end
  end

  // one register for the whole state, all bus pins taken at this edge
  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  logic drive;   // control lines owned by this target
  logic ata_act; // drive cycle running
  always_comb begin
    drive   = (r.state != PIHI_IDLE) && (r.state != PIHI_BUSY);
    ata_act = (r.state == PIHI_SETUP) || (r.state == PIHI_STROBE);
  end

  // bus handshakes; stop rides with target ready while frame is low
  assign devsel_n_o    = ~(drive && r.state != PIHI_TURN);
  assign trdy_n_o      = ~(r.state == PIHI_READY);
  assign stop_n_o      = ~((r.state == PIHI_RETRY) ||
                           (r.state == PIHI_STOPW) ||
                           (r.state == PIHI_READY && !frame_n_i));
  assign devsel_n_oe_o = drive;
  assign trdy_n_oe_o   = drive;
  assign stop_n_oe_o   = drive;
  assign ad_o          = r.ad_out;
  assign ad_oe_o       = (r.state == PIHI_READY) && r.is_read;

  // drive strobes; the live strap floats every drive output
  logic stb;  // strobe phase
  assign stb = r.state == PIHI_STROBE;
  assign pri_chip_select_0_n_o = ~(ata_act && !r.chan && !r.cs1);
  assign pri_chip_select_1_n_o = ~(ata_act && !r.chan && r.cs1);
  assign pri_io_read_n_o       = ~(stb && !r.chan && r.is_read);
  assign pri_io_write_n_o      = ~(stb && !r.chan && !r.is_read);
  assign pri_addr_o            = r.reg_addr;
  assign pri_data_o            = r.wdata;
  assign pri_ctl_oe_o          = ~float_q;
  assign pri_data_oe_o = ata_act && !r.chan && !r.is_read && !float_q;
  assign sec_chip_select_0_n_o = ~(ata_act && r.chan && !r.cs1);
  assign sec_chip_select_1_n_o = ~(ata_act && r.chan && r.cs1);
  assign sec_io_read_n_o       = ~(stb && r.chan && r.is_read);
  assign sec_io_write_n_o      = ~(stb && r.chan && !r.is_read);
  assign sec_addr_o            = r.reg_addr;
  assign sec_data_o            = r.wdata;
  assign sec_ctl_oe_o          = ~float_q;
  assign sec_data_oe_o = ata_act && r.chan && !r.is_read && !float_q;

  // strap catcher and serial load request
  pihi_strap u_strap (
    .core_clk_i      (core_clk_i),
    .rst_i           (rst_i),
    .strap_i         (strap_i),
    .load_done_i     (serial_load_done_i),
    .strap_latched_o (strap_latched_o),
    .load_req_o      (loading),
    .float_o         (float_q)
  );
  assign serial_load_req_o = loading;

  // legacy interrupt routes, one per channel
  pihi_irq u_pri_irq (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .intrq_i    (pri_intrq_i),
    .native_i   (pri_native_i),
    .irq_o      (primary_legacy_irq_o),
    .irq_oe_o   (primary_legacy_irq_oe_o)
  );
  pihi_irq u_sec_irq (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .intrq_i    (sec_intrq_i),
    .native_i   (sec_native_i),
    .irq_o      (secondary_legacy_irq_o),
    .irq_oe_o   (secondary_legacy_irq_oe_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // named steps of a claimed access
  sequence cfg_addr_s;
    addr_ph && cfg_hit && !loading;
  endsequence
  sequence claimed_s;
    !devsel_n_o && devsel_n_oe_o;
  endsequence

  cfg_claim_a: assert property (
    addr_ph && !idsel_i && !io_hit |=> devsel_n_o)
    else $error("access claimed without select or window");

  devsel_claim_a: assert property (
    cfg_addr_s or (addr_ph && io_hit) |=> claimed_s)
    else $error("decoded access not claimed");

  phase_wait_a: assert property (
    !trdy_n_o && irdy_n_i |=> !trdy_n_o)
    else $error("target ready dropped before initiator ready");

  phase_done_a: assert property (
    !trdy_n_o && !irdy_n_i |=> trdy_n_o)
    else $error("data phase did not complete");

  read_valid_a: assert property (
    !trdy_n_o && r.is_read |-> ad_oe_o)
    else $error("read target ready without data driven");

  write_take_a: assert property (
    r.state == PIHI_WDATA && irdy_n_i |=> trdy_n_o)
    else $error("write ready before data taken");

  stop_burst_a: assert property (
    !trdy_n_o && !frame_n_i |-> !stop_n_o)
    else $error("burst not disconnected");

  retry_load_a: assert property (
    addr_ph && cfg_hit && loading |=> !stop_n_o && trdy_n_o)
    else $error("config access during load not retried");

  ata_float_a: assert property (
    float_q |-> !pri_ctl_oe_o && !sec_ctl_oe_o &&
      !pri_data_oe_o && !sec_data_oe_o)
    else $error("drive outputs driven while floated");

endmodule // pihi_top

// ### test/pihi_drive_model.sv
// drive model: one disk drive on a channel of the host interface
// assumes low active strobes and a bench that supplies the read word
module pihi_drive_model (
  input  wire logic        core_clk_i,
  input  wire logic        io_read_n_i,
  input  wire logic        io_write_n_i,
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] rd_word_i,
  output wire logic [15:0] data_o,
  output var  logic [15:0] wr_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released bus shows the inverse word, so stale data cannot match
  assign data_o = io_read_n_i ? ~rd_word_i : rd_word_i;
  // keep the word seen while the write strobe is low
  always @(posedge core_clk_i) begin
    if (!io_write_n_i) begin
      wr_word_o <= data_i;
    end
  end
endmodule // pihi_drive_model

// ### test/pihi_top_bench.sv
// bench for the disk host interface: bus master, strap, interrupts
// assumes pihi_top and two drive models; short strobe for a brief run
module pihi_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 6;                  // strobe cycles used here
  logic        clk = 1'b0, rst = 1'b1;    // bus clock, reset
  logic        idsel = 1'b0, frame_n = 1'b1, irdy_n = 1'b1;
  logic [3:0]  cbe_n = 4'hF;              // command, byte enables
  logic [31:0] ad = 32'h0;                // address/data to target
  logic        strap = 1'b0, load_done = 1'b0;
  logic        pri_nat = 1'b0, sec_nat = 1'b0;
  logic        pri_irq = 1'b0, sec_irq = 1'b0;
  logic [15:0] rd_word = 16'h0;           // word the drives return
  logic [31:0] ad_o;
  logic        ad_oe, trdy_n, devsel_n, stop_n, load_req, latched;
  logic        p_irq, p_irq_oe, s_irq, s_irq_oe, pctl_oe, sctl_oe;
  logic        prd_n, pwr_n, srd_n, swr_n;
  logic [15:0] pdin, pdout, sdin, sdout, p_wr, s_wr;
  int          fail_count = 0, check_count = 0, cyc = 0;
  int          seed = 32'haf15;
  logic [31:0] exp_q[$];                  // expected read bus words
  // command block and control port of each channel
  logic [31:0] tab[4] = '{32'h1F0, 32'h3F6, 32'h170, 32'h376};
  // {channel, cs1_n, cs0_n, index} the drive must see for each port
  logic [5:0]  sel_tab[4] = '{6'h10, 6'h0E, 6'h30, 6'h2E};
  logic [5:0]  sel_seen;                  // selects seen under a strobe
  logic [31:0] w;
  logic        cl, st;
  logic        pcs0_n, pcs1_n, scs0_n, scs1_n;
  logic [2:0]  paddr, saddr;              // drive register index
  logic        t_oe, d_oe, s_oe, pd_oe, sd_oe;

  always #2.5 clk = ~clk;

  pihi_top #(.STROBE_CYC(SC)) dut (
    .core_clk_i(clk), .rst_i(rst), .idsel_i(idsel), .frame_n_i(frame_n),
    .irdy_n_i(irdy_n), .cbe_n_i(cbe_n), .ad_i(ad), .ad_o(ad_o),
    .ad_oe_o(ad_oe), .trdy_n_o(trdy_n), .trdy_n_oe_o(t_oe),
    .devsel_n_o(devsel_n), .devsel_n_oe_o(d_oe), .stop_n_o(stop_n),
    .stop_n_oe_o(s_oe), .strap_i(strap), .serial_load_done_i(load_done),
    .serial_load_req_o(load_req), .strap_latched_o(latched),
    .pri_native_i(pri_nat), .sec_native_i(sec_nat),
    .pri_intrq_i(pri_irq), .sec_intrq_i(sec_irq),
    .primary_legacy_irq_o(p_irq), .primary_legacy_irq_oe_o(p_irq_oe),
    .secondary_legacy_irq_o(s_irq), .secondary_legacy_irq_oe_o(s_irq_oe),
    .pri_chip_select_0_n_o(pcs0_n), .pri_chip_select_1_n_o(pcs1_n),
    .pri_io_read_n_o(prd_n), .pri_io_write_n_o(pwr_n),
    .pri_addr_o(paddr),
    .pri_ctl_oe_o(pctl_oe), .pri_data_i(pdin), .pri_data_o(pdout),
    .pri_data_oe_o(pd_oe), .sec_chip_select_0_n_o(scs0_n),
    .sec_chip_select_1_n_o(scs1_n),
    .sec_io_read_n_o(srd_n), .sec_io_write_n_o(swr_n),
    .sec_addr_o(saddr),
    .sec_ctl_oe_o(sctl_oe), .sec_data_i(sdin), .sec_data_o(sdout),
    .sec_data_oe_o(sd_oe));

  pihi_drive_model pri_drive (.core_clk_i(clk), .io_read_n_i(prd_n),
    .io_write_n_i(pwr_n), .data_i(pdout), .rd_word_i(rd_word),
    .data_o(pdin), .wr_word_o(p_wr));
  pihi_drive_model sec_drive (.core_clk_i(clk), .io_read_n_i(srd_n),
    .io_write_n_i(swr_n), .data_i(sdout), .rd_word_i(rd_word),
    .data_o(sdin), .wr_word_o(s_wr));

  // one comparison; four-state match so unknowns never pass
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // single data phase; irdy is held until the edge that ends it
  task automatic bus_op(input logic [3:0] cmd, input logic [31:0] addr,
      input logic sel, input logic [31:0] wd, output logic claimed,
      output logic stopped);
    int n;
    claimed = 1'b0;
    stopped = 1'b0;
    n = 0;
    @(posedge clk);
    frame_n <= 1'b0;
    cbe_n <= cmd;
    ad <= addr;
    idsel <= sel;
    @(posedge clk);
    // writes get one master wait state with frame still low
    if (cmd[0]) begin
      cbe_n <= 4'h0;
      idsel <= 1'b0;
      @(posedge clk);
    end
    frame_n <= 1'b1;
    irdy_n <= 1'b0;
    ad <= wd;
    cbe_n <= 4'h0;
    idsel <= 1'b0;
    // give up on a claim after five cycles, like a master abort
    while (n < 80) begin
      @(negedge clk);
      n++;
      if (devsel_n === 1'b0) claimed = 1'b1;
      if (stop_n === 1'b0) stopped = 1'b1;
      if (trdy_n === 1'b0 || stopped || (n > 5 && !claimed)) break;
    end
    @(posedge clk);
    irdy_n <= 1'b1;
    repeat (2) @(posedge clk);
    // two idle edges later every target-side driver is off the bus
    @(negedge clk);
    check("bus released", {t_oe, d_oe, s_oe, ad_oe, pd_oe, sd_oe},
          6'h00);
  endtask

  // chip selects and register index seen while a drive strobe is low
  always @(negedge clk) begin
    if (prd_n === 1'b0 || pwr_n === 1'b0)
      sel_seen <= {1'b0, pcs1_n, pcs0_n, paddr};
    if (srd_n === 1'b0 || swr_n === 1'b0)
      sel_seen <= {1'b1, scs1_n, scs0_n, saddr};
  end

  // watcher: a read phase ends at the edge after both readies are low
  always @(negedge clk) begin
    if (trdy_n === 1'b0 && irdy_n === 1'b0 && ad_oe === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected read", 1, 0);
      else
        check("read data", ad_o, exp_q.pop_front());
    end
  end

  // hang guard, far above the 150 or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check("strap latched", latched, 0);
    check("load request", load_req, 1);
    check("pri float", pctl_oe, 0);
    check("sec float", sctl_oe, 0);
    @(posedge clk);
    strap <= 1'b1;
    repeat (4) @(negedge clk);
    check("drive outputs", {pctl_oe, sctl_oe}, 2'b11);
    check("strap held", latched, 0);
    bus_op(4'hA, 32'h0, 1'b1, 32'h0, cl, st);
    check("cfg retry", {cl, st}, 2'b11);
    @(posedge clk);
    load_done <= 1'b1;
    @(posedge clk);
    load_done <= 1'b0;
    repeat (2) @(negedge clk);
    check("load ended", load_req, 0);
    exp_q.push_back(32'h00000000);
    bus_op(4'hA, 32'h0, 1'b1, 32'h0, cl, st);
    check("cfg claim", {cl, st}, 2'b10);
    bus_op(4'hB, 32'h0, 1'b1, 32'hA5A5A5A5, cl, st);
    check("cfg write claim", {cl, st}, 2'b10);
    bus_op(4'hA, 32'h0, 1'b0, 32'h0, cl, st);
    check("cfg no select", cl, 0);
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      rd_word <= w[15:0];
      // control ports sit on lane 2, so their word rides the upper half
      exp_q.push_back(tab[i][1] ? {w[15:0], 16'h0000}
                                : {16'h0000, w[15:0]});
      bus_op(4'h2, tab[i], 1'b0, 32'h0, cl, st);
      check("io read claim", cl, 1);
      check("drive select", sel_seen, sel_tab[i]);
    end
    w = $random(seed);
    bus_op(4'h3, 32'h170, 1'b0, w, cl, st);
    check("io write", {cl, s_wr}, {1'b1, w[15:0]});
    check("write select", sel_seen, 6'h30);
    bus_op(4'h2, 32'h2F0, 1'b0, 32'h0, cl, st);
    check("foreign addr", cl, 0);
    check("strap still", latched, 0);
    @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      pri_nat <= m[0];
      sec_nat <= !m[0];
      pri_irq <= 1'b1;
      sec_irq <= 1'b1;
      repeat (3) @(negedge clk);
      check("pri irq", {p_irq_oe, p_irq}, {!m[0], 1'b1});
      check("sec irq", {s_irq_oe, s_irq}, {m[0], 1'b1});
      @(posedge clk);
      pri_irq <= 1'b0;
      sec_irq <= 1'b0;
      repeat (3) @(negedge clk);
      check("irq low", {p_irq, s_irq}, 0);
      @(posedge clk);
    end
    // second reset with the strap high: no serial load, drives stay on
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check("strap relatched", {latched, load_req}, 2'b10);
    check("drives after reset", {pctl_oe, sctl_oe}, 2'b11);
    report_and_stop();
  end
endmodule // pihi_top_bench
